// file: design/dio_ctrl.sv
// How it works
// - fast-reset port reads all ones, starts reset
// - fast reset ORed with keyboard reset request
// - control bit 0 resets after 6.72us delay
// - reset pulse high exactly 16 clocks
// - reset bit holds until rewritten or reset
// - fast-reset read uses same timing
// - vendor disable blocks fast-reset, coproc-reset, speed and lock ports
// - busy-clear write clears coprocessor busy flop
// - coproc reset write gives 40-clock pulse
// - ready held inactive 50 more clocks
// - reset write blocked when block bit set
// - fast-speed write restores full speed; reset default
// - slow-speed write engages divider with code
// - divider code range covers 12-33 MHz
// - speed ports act only when vendor enabled
// - speed port reads have no effect
// - unlock and lock ports gate config writes
// - locked writes to ECh-EFh ignored
// - vendor disable also kills lock ports
module dio_ctrl
  import dio_pkg::*;
(
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_arst_n,
  // host io cycle
  input  wire dio_io_t          i_io,
  // settings and external events
  input  wire dio_misc_t        i_misc,
  input  wire logic             i_kbc_reset_request_n,
  input  wire logic             i_coproc_error_in_n,
  // read data
  output logic [7:0]            o_rdata,
  output logic                  o_rdata_valid,
  // outputs
  output logic                  o_cpu_reset,
  output logic                  o_coproc_reset_out,
  output logic                  o_cpu_ready_block,
  output logic                  o_coproc_busy_to_cpu_n,
  output logic                  o_coproc_request_to_cpu,
  output logic                  o_a20_gate,
  output logic                  o_slow_mode,
  output logic [DIV_W-1:0]      o_div_code,
  output logic                  o_cfg_write_en
);

  // synchroniser stages
  logic             kbc_s1_q;
  logic             kbc_s2_q;
  logic             err_s1_q;
  logic             err_s2_q;
  logic             err_s2_dly_q;
  // register bank
  logic [7:0]       rdata_q;
  logic [7:0]       rdata_d;
  logic             rvalid_q;
  logic             rvalid_d;
  logic             sysctl_rst_q;
  logic             sysctl_rst_d;
  logic             a20_q;
  logic             a20_d;
  logic             busy_q;
  logic             busy_d;
  logic             busy_n_q;
  logic             busy_n_d;
  logic             slow_q;
  logic             slow_d;
  logic             unlock_q;
  logic             unlock_d;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  // sequencers
  dio_rst_st_t      rst_st_q;
  dio_rst_st_t      rst_st_d;
  logic [CNT_W-1:0] rst_cnt_q;
  logic [CNT_W-1:0] rst_cnt_d;
  logic             cpu_rst_q;
  logic             cpu_rst_d;
  dio_cop_st_t      cop_st_q;
  dio_cop_st_t      cop_st_d;
  logic [CNT_W-1:0] cop_cnt_q;
  logic [CNT_W-1:0] cop_cnt_d;
  logic             cop_out_q;
  logic             cop_out_d;
  logic             rdy_blk_q;
  logic             rdy_blk_d;
  // decode
  logic             vfen;
  logic             wr_sysctl;
  logic             fast_rd;
  logic             rst_req;
  logic             cfg_port_wr;
  logic             err_fall;

  // pins pass two flops first
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      kbc_s1_q <= 1'b1;
      kbc_s2_q <= 1'b1;
    end else begin
      kbc_s1_q <= i_kbc_reset_request_n;
      kbc_s2_q <= kbc_s1_q;
    end
  end

  // third stage only delays the clean copy, for edge detection
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      err_s1_q     <= 1'b1;
      err_s2_q     <= 1'b1;
      err_s2_dly_q <= 1'b1;
    end else begin
      err_s1_q     <= i_coproc_error_in_n;
      err_s2_q     <= err_s1_q;
      err_s2_dly_q <= err_s2_q;
    end
  end

  always_comb begin
    vfen        = !i_misc.vendor_feature_disable;
    // lock covers the whole ECh-EFh window
    cfg_port_wr = i_io.addr >= CFG_INDEX_ADDR && i_io.addr <= FAST_RST_ADDR;
    wr_sysctl   = i_io.wr && i_io.addr == SYSCTL_ADDR;
    fast_rd     = i_io.rd && i_io.addr == FAST_RST_ADDR && vfen;
    // system control port stays live regardless of vendor bit
    rst_req     = fast_rd || (wr_sysctl && i_io.wdata[SYSCTL_RST_BIT]);
    // edge, not level: a held error sets busy only once
    err_fall    = err_s2_dly_q && !err_s2_q;
  end

  // register bank
  always_comb begin
    rdata_d      = 8'h00;
    rvalid_d     = i_io.rd;
    sysctl_rst_d = sysctl_rst_q;
    a20_d        = a20_q;
    busy_d       = busy_q;
    slow_d       = slow_q;
    div_d        = div_q;
    unlock_d     = unlock_q;
    if (i_io.rd) begin
      unique case (i_io.addr)
        // fixed all-ones answer, data ignored
        FAST_RST_ADDR: rdata_d = ALL_ONES;
        SYSCTL_ADDR:   rdata_d = SYSCTL_FILL | {6'h00, a20_q, sysctl_rst_q};
        // speed and lock ports: no side effect, zero returned
        default:       rdata_d = 8'h00;
      endcase
    end
    if (wr_sysctl) begin
      sysctl_rst_d = i_io.wdata[SYSCTL_RST_BIT];
      a20_d        = i_io.wdata[SYSCTL_A20_BIT];
    end
    // locked writes into the config window fall through untouched
    if (i_io.wr && !(cfg_port_wr && !unlock_q)) begin
      unique case (i_io.addr)
        BUSY_CLR_ADDR:   busy_d = 1'b0;
        SLOW_ADDR:       if (vfen) begin
          slow_d = 1'b1;
          div_d  = i_misc.div_code;
        end
        FAST_ADDR:       if (vfen) slow_d = 1'b0;
        CFG_LOCK_ADDR:   if (vfen) unlock_d = 1'b0;
        CFG_UNLOCK_ADDR: if (vfen) unlock_d = 1'b1;
        default:         ;
      endcase
    end
    // new error wins over a clear in the same cycle
    if (err_fall) begin
      busy_d = 1'b1;
    end
    // low-active copy has its own flop so the pin comes straight from one
    busy_n_d = !busy_d;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q      <= 8'h00;
      rvalid_q     <= 1'b0;
      sysctl_rst_q <= 1'b0;
      a20_q        <= 1'b0;
      busy_q       <= 1'b0;
      busy_n_q     <= 1'b1;
      slow_q       <= 1'b0;
      div_q        <= '0;
      unlock_q     <= 1'b1;
    end else begin
      rdata_q      <= rdata_d;
      rvalid_q     <= rvalid_d;
      sysctl_rst_q <= sysctl_rst_d;
      a20_q        <= a20_d;
      busy_q       <= busy_d;
      busy_n_q     <= busy_n_d;
      slow_q       <= slow_d;
      div_q        <= div_d;
      unlock_q     <= unlock_d;
    end
  end

  // cpu reset sequencer; a request during a pulse is dropped
  always_comb begin
    rst_st_d  = rst_st_q;
    rst_cnt_d = rst_cnt_q;
    cpu_rst_d = 1'b0;
    unique case (rst_st_q)
      DIO_RST_IDLE: if (rst_req) begin
        // count rounds up, so the gap never falls short of the minimum
        rst_st_d  = DIO_RST_DELAY;
        rst_cnt_d = CNT_W'(RST_DELAY_CYC - 1);
      end
      DIO_RST_DELAY: begin
        rst_cnt_d = rst_cnt_q - 1'b1;
        if (rst_cnt_q == '0) begin
          rst_st_d  = DIO_RST_PULSE;
          rst_cnt_d = CNT_W'(CPU_RST_CYC - 1);
          cpu_rst_d = 1'b1;
        end
      end
      DIO_RST_PULSE: begin
        rst_cnt_d = rst_cnt_q - 1'b1;
        cpu_rst_d = rst_cnt_q != '0;
        if (rst_cnt_q == '0) rst_st_d = DIO_RST_IDLE;
      end
      default: rst_st_d = DIO_RST_IDLE;
    endcase
    // keyboard request acts directly, ORed in
    if (!kbc_s2_q) cpu_rst_d = 1'b1;
  end

  // coprocessor reset and ready hold
  // a write while busy is dropped; the pulse is never stretched
  always_comb begin
    cop_st_d  = cop_st_q;
    cop_cnt_d = cop_cnt_q;
    cop_out_d = 1'b0;
    rdy_blk_d = 1'b0;
    unique case (cop_st_q)
      DIO_COP_IDLE: if (i_io.wr && i_io.addr == COP_RST_ADDR && vfen
                        && !i_misc.coproc_reset_write_block) begin
        cop_st_d  = DIO_COP_PULSE;
        cop_cnt_d = CNT_W'(COP_RST_CYC - 1);
        cop_out_d = 1'b1;
        rdy_blk_d = 1'b1;
      end
      DIO_COP_PULSE: begin
        cop_cnt_d = cop_cnt_q - 1'b1;
        cop_out_d = cop_cnt_q != '0;
        rdy_blk_d = 1'b1;
        if (cop_cnt_q == '0) begin
          cop_st_d  = DIO_COP_HOLD;
          cop_cnt_d = CNT_W'(COP_HOLD_CYC - 1);
        end
      end
      DIO_COP_HOLD: begin
        cop_cnt_d = cop_cnt_q - 1'b1;
        rdy_blk_d = cop_cnt_q != '0;
        if (cop_cnt_q == '0) cop_st_d = DIO_COP_IDLE;
      end
      default: cop_st_d = DIO_COP_IDLE;
    endcase
  end

  // cpu reset sequencer state
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_st_q  <= DIO_RST_IDLE;
      rst_cnt_q <= '0;
      cpu_rst_q <= 1'b0;
    end else begin
      rst_st_q  <= rst_st_d;
      rst_cnt_q <= rst_cnt_d;
      cpu_rst_q <= cpu_rst_d;
    end
  end

  // coprocessor sequencer state
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cop_st_q  <= DIO_COP_IDLE;
      cop_cnt_q <= '0;
      cop_out_q <= 1'b0;
      rdy_blk_q <= 1'b0;
    end else begin
      cop_st_q  <= cop_st_d;
      cop_cnt_q <= cop_cnt_d;
      cop_out_q <= cop_out_d;
      rdy_blk_q <= rdy_blk_d;
    end
  end

  // every output below is a flop, no logic after it
  assign o_rdata                 = rdata_q;
  assign o_rdata_valid           = rvalid_q;
  assign o_cpu_reset             = cpu_rst_q;
  assign o_coproc_reset_out      = cop_out_q;
  assign o_cpu_ready_block       = rdy_blk_q;
  assign o_coproc_busy_to_cpu_n  = busy_n_q;
  assign o_coproc_request_to_cpu = busy_q;
  assign o_a20_gate              = a20_q;
  assign o_slow_mode             = slow_q;
  assign o_div_code              = div_q;
  assign o_cfg_write_en          = unlock_q;

endmodule

// file: design/dio_pkg.sv
package dio_pkg;
  // clock and timing
  localparam int unsigned SYS_CLK_HZ       = 25_000_000;
  localparam int unsigned RST_DELAY_NS     = 6720;
  localparam int unsigned SYS_CLK_NS       = 1_000_000_000 / SYS_CLK_HZ;
  localparam int unsigned RST_DELAY_CYC    = (RST_DELAY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned CPU_RST_CYC      = 16;
  localparam int unsigned COP_RST_CYC      = 40;
  localparam int unsigned COP_HOLD_CYC     = 50;
  localparam int unsigned CNT_W            = 8;

  // port addresses
  localparam logic [15:0] SYSCTL_ADDR      = 16'h0092;
  localparam logic [15:0] CFG_INDEX_ADDR   = 16'h00EC;
  localparam logic [15:0] FAST_RST_ADDR    = 16'h00EF;
  localparam logic [15:0] BUSY_CLR_ADDR    = 16'h00F0;
  localparam logic [15:0] COP_RST_ADDR     = 16'h00F1;
  localparam logic [15:0] SLOW_ADDR        = 16'h00F4;
  localparam logic [15:0] FAST_ADDR        = 16'h00F5;
  localparam logic [15:0] CFG_LOCK_ADDR    = 16'h00F9;
  localparam logic [15:0] CFG_UNLOCK_ADDR  = 16'h00FB;

  // fields
  localparam int unsigned SYSCTL_RST_BIT   = 0;
  localparam int unsigned SYSCTL_A20_BIT   = 1;
  localparam int unsigned VFD_BIT          = 7;
  localparam int unsigned CRWB_BIT         = 6;
  localparam int unsigned DIV_W            = 3;
  localparam logic [7:0]  ALL_ONES         = 8'hFF;
  localparam logic [7:0]  SYSCTL_FILL      = 8'hFC;

  typedef enum logic [1:0] {
    DIO_RST_IDLE  = 2'b00,
    DIO_RST_DELAY = 2'b01,
    DIO_RST_PULSE = 2'b11
  } dio_rst_st_t;

  typedef enum logic [1:0] {
    DIO_COP_IDLE  = 2'b00,
    DIO_COP_PULSE = 2'b01,
    DIO_COP_HOLD  = 2'b11
  } dio_cop_st_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dio_io_t;

  typedef struct packed {
    logic             vendor_feature_disable;
    logic             coproc_reset_write_block;
    logic [DIV_W-1:0] div_code;
  } dio_misc_t;
endpackage

// file: verification/dio_ctrl_bench.sv
module dio_ctrl_bench import dio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  dio_io_t          io;
  dio_misc_t        misc = '0;
  logic             kbc_n = 1'b1;
  logic             err_n = 1'b1;
  logic [7:0]       rdata, q;
  logic             rv, cpu_rst, cop_rst, rdy_blk, busy_n, req, a20, slow, cfg_en;
  logic [DIV_W-1:0] div;
  int               error_cnt = 0;
  int               check_count = 0;
  always #20 clk = ~clk;
  dio_host dio_host_i (.i_sys_clk(clk), .i_rdata(rdata), .o_io(io));
  dio_ctrl dio_ctrl_i (.i_sys_clk(clk), .i_arst_n(rst_n), .i_io(io), .i_misc(misc),
    .i_kbc_reset_request_n(kbc_n), .i_coproc_error_in_n(err_n), .o_rdata(rdata),
    .o_rdata_valid(rv), .o_cpu_reset(cpu_rst), .o_coproc_reset_out(cop_rst),
    .o_cpu_ready_block(rdy_blk), .o_coproc_busy_to_cpu_n(busy_n),
    .o_coproc_request_to_cpu(req), .o_a20_gate(a20), .o_slow_mode(slow),
    .o_div_code(div), .o_cfg_write_en(cfg_en));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    dio_host_i.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    dio_host_i.acc(1'b0, a, 8'h00, q);
    chk(q, exp);
    chk(rv, 1'b1);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk(slow, 1'b0);
    chk(busy_n, 1'b1);
    chk(cfg_en, 1'b1);
    wr(SYSCTL_ADDR, 8'h03);
    rd(SYSCTL_ADDR, ALL_ONES);
    tick(200);
    chk(a20, 1'b1);
    rd(SYSCTL_ADDR, ALL_ONES);
    wr(SYSCTL_ADDR, 8'h02);
    rd(SYSCTL_ADDR, 8'hFE);
    rd(FAST_RST_ADDR, ALL_ONES);
    tick(170);
    chk(cpu_rst, 1'b1);
    tick(30);
    misc.vendor_feature_disable = 1'b1;
    rd(FAST_RST_ADDR, ALL_ONES);
    tick(170);
    chk(cpu_rst, 1'b0);
    wr(SLOW_ADDR, 8'h00);
    chk(slow, 1'b0);
    wr(CFG_LOCK_ADDR, 8'h00);
    chk(cfg_en, 1'b1);
    wr(SYSCTL_ADDR, 8'h03);
    tick(170);
    chk(cpu_rst, 1'b1);
    tick(20);
    misc = '{vendor_feature_disable: 1'b0, coproc_reset_write_block: 1'b1, div_code: 3'h5};
    wr(SLOW_ADDR, 8'hA5);
    chk(div, 3'h5);
    dio_host_i.acc(1'b0, FAST_ADDR, 8'h00, q);
    chk(slow, 1'b1);
    wr(FAST_ADDR, 8'h00);
    chk(slow, 1'b0);
    wr(COP_RST_ADDR, 8'hFF);
    chk(cop_rst, 1'b0);
    misc.coproc_reset_write_block = 1'b0;
    wr(COP_RST_ADDR, 8'h00);
    chk(cop_rst, 1'b1);
    tick(45);
    chk(rdy_blk, 1'b1);
    tick(50);
    chk(rdy_blk, 1'b0);
    wr(CFG_LOCK_ADDR, 8'h00);
    chk(cfg_en, 1'b0);
    wr(CFG_UNLOCK_ADDR, 8'h00);
    chk(cfg_en, 1'b1);
    // error edge and clear land on the same clock: the set must win
    err_n = 1'b0;
    tick(1);
    wr(BUSY_CLR_ADDR, 8'h00);
    chk(req, 1'b1);
    tick(5);
    chk(busy_n, 1'b0);
    err_n = 1'b1;
    wr(BUSY_CLR_ADDR, 8'h00);
    chk(busy_n, 1'b1);
    kbc_n = 1'b0;
    tick(16);
    kbc_n = 1'b1;
    chk(cpu_rst, 1'b1);
    tick(10);
    // external reset in mid-run clears the latched control bits
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    rd(SYSCTL_ADDR, SYSCTL_FILL);
    chk(a20, 1'b0);
    end_sim();
  end
  // run needs about 940 cycles; margin for a stuck handshake
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule

// file: verification/dio_ctrl_sva.sv
module dio_ctrl_chk
  import dio_pkg::*;
(
  // watched ports
  input wire logic             i_sys_clk,
  input wire logic             i_arst_n,
  input wire dio_io_t          i_io,
  input wire dio_misc_t        i_misc,
  input wire logic             i_kbc_reset_request_n,
  input wire logic [7:0]       o_rdata,
  input wire logic             o_cpu_reset,
  input wire logic             o_coproc_reset_out,
  input wire logic             o_cpu_ready_block,
  input wire logic             o_slow_mode,
  input wire logic [DIV_W-1:0] o_div_code,
  input wire logic             o_cfg_write_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  logic [7:0] hi_q;
  logic       en;
  logic       cop_wr;
  assign en = !i_misc.vendor_feature_disable;
  assign cop_wr = i_io.wr && i_io.addr == COP_RST_ADDR && !o_cpu_ready_block;
  // counts reset-high cycles so the pulse width is checked past the repetition limit
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= o_cpu_reset ? hi_q + 8'h01 : 8'h00;
    end
  end
  rd_ones_a: assert property (i_io.rd && i_io.addr == FAST_RST_ADDR |=> o_rdata == ALL_ONES)
    else $error("fast reset port read wrong");
  rst_delay_a: assert property (((i_io.rd && i_io.addr == FAST_RST_ADDR && en)
    || (i_io.wr && i_io.addr == SYSCTL_ADDR && i_io.wdata[0])) && !o_cpu_reset
    |-> ##168 !o_cpu_reset ##1 o_cpu_reset) else $error("cpu reset delay wrong");
  rst_width_a: assert property ($fell(o_cpu_reset) |-> hi_q == 8'h10)
    else $error("cpu reset width wrong");
  kbc_or_a: assert property (!i_kbc_reset_request_n [*4] |=> o_cpu_reset)
    else $error("keyboard reset not passed");
  cop_pulse_a: assert property (cop_wr && en && !i_misc.coproc_reset_write_block
    |=> o_coproc_reset_out ##39 o_coproc_reset_out ##1 !o_coproc_reset_out)
    else $error("coproc reset pulse wrong");
  rdy_hold_a: assert property ($fell(o_coproc_reset_out)
    |-> o_cpu_ready_block ##49 o_cpu_ready_block ##1 !o_cpu_ready_block)
    else $error("ready hold wrong");
  cop_block_a: assert property (cop_wr && i_misc.coproc_reset_write_block
    |=> !o_coproc_reset_out) else $error("blocked coproc reset fired");
  slow_sel_a: assert property (i_io.wr && i_io.addr == SLOW_ADDR && en
    |=> o_slow_mode && o_div_code == $past(i_misc.div_code)) else $error("slow select wrong");
  fast_sel_a: assert property (i_io.wr && i_io.addr == FAST_ADDR && en |=> !o_slow_mode)
    else $error("fast select wrong");
  lock_a: assert property (i_io.wr && i_io.addr == CFG_LOCK_ADDR && en |=> !o_cfg_write_en)
    else $error("config lock wrong");
  cover property ($fell(o_cpu_reset));
  cover property ($fell(o_cpu_ready_block));
  cover property ($rose(o_slow_mode));
endmodule

bind dio_ctrl dio_ctrl_chk dio_ctrl_chk_i (.i_sys_clk, .i_arst_n, .i_io, .i_misc,
  .i_kbc_reset_request_n, .o_rdata, .o_cpu_reset, .o_coproc_reset_out, .o_cpu_ready_block,
  .o_slow_mode, .o_div_code, .o_cfg_write_en);

// file: verification/dio_host.sv
module dio_host
  import dio_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  output dio_io_t         o_io
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_io = '{rd: 1'b0, wr: 1'b0, addr: 16'hFFFF, wdata: 8'hFF};
  end
  // one-cycle strobe; idle address and data flip so stale values never pass for valid
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge i_sys_clk);
    o_io = '{rd: !w, wr: w, addr: a, wdata: d};
    @(negedge i_sys_clk);
    q = i_rdata;
    o_io = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
